// ### hdl/halfband_interpolation_chain.sv
// Purpose: 1x/2x/4x/8x halfband interpolator with digital mixer
// Assumes: one sample taken on each take_out cycle, output every clock
// Notes:   a configuration write restarts the rate phase counter

`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// halfband stage: one input sample gives two output samples
// ****************************************************************
module halfband_stage
	import halfband_pkg::*;
#(
	parameter int                     K      = 3,
	parameter int                     SHIFT  = 9,
	parameter logic signed [CW-1:0]   CENTER = 16'sh200,
	parameter logic signed [CW-1:0]   COEF [K] = '{default: 16'sh0}
)(
	input  wire logic                 clock_in,
	input  wire logic                 rstn_in,
	input  wire logic                 in_stb_in,
	input  wire logic                 half_stb_in,
	input  wire logic signed [DW-1:0] x_in,
	output logic                      out_stb_out,
	output logic signed [DW-1:0]      y_out
);
	logic signed [DW-1:0]   taps [2*K-1];
	logic signed [DW-1:0]   hold_b;
	logic signed [ACCW-1:0] acc_a;
	logic signed [ACCW-1:0] acc_b;

	// even phase: all symmetric side taps; odd phase: centre tap only
	always_comb
	begin
		logic signed [DW-1:0] t;
		logic signed [CW-1:0] c;
		t = x_in;
		c = COEF[0];
		acc_a = '0;
		for (int m = 0; m < 2*K; m++)
		begin
			t = (m == 0) ? x_in : taps[m-1];
			c = (m < K) ? COEF[m] : COEF[2*K-1-m];
			acc_a = acc_a + ACCW'(t) * ACCW'(c);
		end
		t = (K == 1) ? x_in : taps[K-2];
		acc_b = ACCW'(t) * ACCW'(CENTER);
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int m = 0; m < 2*K-1; m++)
				taps[m] <= '0;
		end
		else if (in_stb_in)
		begin
			taps[0] <= x_in;
			for (int m = 1; m < 2*K-1; m++)
				taps[m] <= taps[m-1];
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			y_out       <= '0;
			hold_b      <= '0;
			out_stb_out <= 1'b0;
		end
		else
		begin
			out_stb_out <= in_stb_in | half_stb_in;
			if (in_stb_in)
			begin
				y_out  <= sat16(acc_a, SHIFT);
				hold_b <= sat16(acc_b, SHIFT);
			end
			else if (half_stb_in)
				y_out <= hold_b;
		end
	end
endmodule

// ****************************************************************
// top: configuration port, rate control, filter cascade, mixer
// ****************************************************************
module halfband_interpolation_chain
	import halfband_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	input  wire iq_s        data_in,
	output logic [7:0]      rd_data_out,
	output logic            take_out,
	output iq_s             data_out
);
	logic [7:0] cfg;
	logic [2:0] cnt;
	logic [2:0] mph;
	logic [3:0] factor;
	logic [2:0] mask;
	logic       stb1;
	iq_s        in_reg;
	iq_s        sel;
	iq_s        mixed;
	logic [2:0] half_stb;
	logic [2:0] out_stb_i;
	logic [2:0] out_stb_q;
	logic signed [DW-1:0] y_i [3];
	logic signed [DW-1:0] y_q [3];
	logic signed [16:0] cos_v;
	logic signed [16:0] sin_v;
	logic signed [ACCW-1:0] ic;
	logic signed [ACCW-1:0] is;
	logic signed [ACCW-1:0] qc;
	logic signed [ACCW-1:0] qs;
	interp_e interp;
	mod_e    mod_sel;

	assign interp  = interp_e'(cfg[INTERP_LSB +: 2]);
	assign mod_sel = mod_e'(cfg[MOD_LSB +: 2]);
	assign factor  = 4'h1 << interp;
	assign mask    = 3'(factor - 4'h1);

	// ************************************************************
	// register port
	// ************************************************************
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cfg <= CFG_RESET;
		else if (wr_in && addr_in == CFG_ADDR)
			cfg <= wr_data_in;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rd_data_out <= 8'h00;
		else if (rd_in && addr_in == CFG_ADDR)
			rd_data_out <= cfg;
		else if (rd_in && addr_in == STAT_ADDR)
			rd_data_out <= {cnt, mph, 2'h0};
		else
			rd_data_out <= 8'h00;
	end

	// ************************************************************
	// rate control
	// ************************************************************
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt      <= '0;
			take_out <= 1'b1;
		end
		else if (wr_in && addr_in == CFG_ADDR)
		begin
			cnt      <= '0;
			take_out <= 1'b1;
		end
		else
		begin
			cnt      <= cnt + 3'h1;
			take_out <= ((cnt + 3'h1) & mask) == 3'h0;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			in_reg <= '0;
			stb1   <= 1'b0;
		end
		else
		begin
			stb1 <= take_out && interp != INTERP_1X;
			if (take_out)
				in_reg <= data_in;
		end
	end

	// second output of stage n falls halfway through its input period
	always_comb
	begin
		logic [2:0] per;
		per = mask;
		for (int n = 0; n < 3; n++)
		begin
			per = 3'(mask >> n);
			half_stb[n] = (n < int'(interp)) &&
				(((cnt - 3'(n + 1)) & per) == (per >> 1) + 3'h1);
		end
	end

	// ************************************************************
	// filter cascade
	// ************************************************************
	halfband_stage #(.K(HB1_K), .SHIFT(HB1_SHIFT), .CENTER(HB1_CENTER),
		.COEF(HB1_COEF)) hb1_i (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(stb1), .half_stb_in(half_stb[0]), .x_in(in_reg.i),
		.out_stb_out(out_stb_i[0]), .y_out(y_i[0]));
	halfband_stage #(.K(HB1_K), .SHIFT(HB1_SHIFT), .CENTER(HB1_CENTER),
		.COEF(HB1_COEF)) hb1_q (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(stb1), .half_stb_in(half_stb[0]), .x_in(in_reg.q),
		.out_stb_out(out_stb_q[0]), .y_out(y_q[0]));
	halfband_stage #(.K(HB2_K), .SHIFT(HB2_SHIFT), .CENTER(HB2_CENTER),
		.COEF(HB2_COEF)) hb2_i (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(out_stb_i[0] && interp > INTERP_2X),
		.half_stb_in(half_stb[1]), .x_in(y_i[0]),
		.out_stb_out(out_stb_i[1]), .y_out(y_i[1]));
	halfband_stage #(.K(HB2_K), .SHIFT(HB2_SHIFT), .CENTER(HB2_CENTER),
		.COEF(HB2_COEF)) hb2_q (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(out_stb_q[0] && interp > INTERP_2X),
		.half_stb_in(half_stb[1]), .x_in(y_q[0]),
		.out_stb_out(out_stb_q[1]), .y_out(y_q[1]));
	halfband_stage #(.K(HB3_K), .SHIFT(HB3_SHIFT), .CENTER(HB3_CENTER),
		.COEF(HB3_COEF)) hb3_i (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(out_stb_i[1] && interp == INTERP_8X),
		.half_stb_in(half_stb[2]), .x_in(y_i[1]),
		.out_stb_out(out_stb_i[2]), .y_out(y_i[2]));
	halfband_stage #(.K(HB3_K), .SHIFT(HB3_SHIFT), .CENTER(HB3_CENTER),
		.COEF(HB3_COEF)) hb3_q (.clock_in(clock_in), .rstn_in(rstn_in),
		.in_stb_in(out_stb_q[1] && interp == INTERP_8X),
		.half_stb_in(half_stb[2]), .x_in(y_q[1]),
		.out_stb_out(out_stb_q[2]), .y_out(y_q[2]));

	// ************************************************************
	// stage select, zero stuffing and mixer
	// ************************************************************
	always_comb
	begin
		unique case (interp)
			INTERP_1X: sel = in_reg;
			INTERP_2X: sel = '{i: y_i[0], q: y_q[0]};
			INTERP_4X: sel = '{i: y_i[1], q: y_q[1]};
			INTERP_8X: sel = '{i: y_i[2], q: y_q[2]};
		endcase
		if (cfg[ZSTUFF_BIT] && cnt[0])
			sel = '0;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			mph <= '0;
		else
		begin
			unique case (mod_sel)
				MOD_NONE:    mph <= '0;
				MOD_HALF:    mph <= mph + 3'h4;
				MOD_QUARTER: mph <= mph + 3'h2;
				MOD_EIGHTH:  mph <= mph + 3'h1;
			endcase
		end
	end

	always_comb
	begin
		unique case (mph)
			3'h0: begin cos_v = MIX_ONE;   sin_v = '0;        end
			3'h1: begin cos_v = MIX_ROOT;  sin_v = MIX_ROOT;  end
			3'h2: begin cos_v = '0;        sin_v = MIX_ONE;   end
			3'h3: begin cos_v = -MIX_ROOT; sin_v = MIX_ROOT;  end
			3'h4: begin cos_v = -MIX_ONE;  sin_v = '0;        end
			3'h5: begin cos_v = -MIX_ROOT; sin_v = -MIX_ROOT; end
			3'h6: begin cos_v = '0;        sin_v = -MIX_ONE;  end
			3'h7: begin cos_v = MIX_ROOT;  sin_v = -MIX_ROOT; end
		endcase
		if (!cfg[SIGN_BIT])
			sin_v = -sin_v;
		ic = ACCW'(sel.i) * ACCW'(cos_v);
		is = ACCW'(sel.i) * ACCW'(sin_v);
		qc = ACCW'(sel.q) * ACCW'(cos_v);
		qs = ACCW'(sel.q) * ACCW'(sin_v);
		if (mod_sel == MOD_NONE)
			mixed = sel;
		else if (cfg[REAL_BIT])
		begin
			mixed.i = sat16(ic, MIX_SHIFT);
			mixed.q = sat16(qs, MIX_SHIFT);
		end
		else
		begin
			mixed.i = sat16(ic - qs, MIX_SHIFT);
			mixed.q = sat16(is + qc, MIX_SHIFT);
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			data_out <= '0;
		else
			data_out <= mixed;
	end
endmodule

`default_nettype wire

// ### hdl/halfband_pkg.sv
// Purpose: constants and types for the halfband interpolation chain
// Assumes: 16-bit two's complement I/Q samples, one DAC-rate clock
// Notes:   coefficient tables hold one side of each symmetric filter

package halfband_pkg;

	localparam int DW   = 16;
	localparam int CW   = 16;
	localparam int ACCW = 40;

	// register map
	localparam logic [7:0] CFG_ADDR  = 8'h01;
	localparam logic [7:0] STAT_ADDR = 8'h02;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// configuration field positions
	localparam int INTERP_LSB = 6;
	localparam int MOD_LSB    = 4;
	localparam int ZSTUFF_BIT = 3;
	localparam int REAL_BIT   = 2;
	localparam int SIGN_BIT   = 1;

	// coefficient tables, outermost tap first
	localparam int HB1_K     = 11;
	localparam int HB1_SHIFT = 14;
	localparam logic signed [CW-1:0] HB1_CENTER = 16'sh4000;
	localparam logic signed [CW-1:0] HB1_COEF [HB1_K] = '{
		16'sh8, -16'sh1d, 16'sh43, -16'sh86, 16'shf4, -16'sh19e,
		16'sh2a1, -16'sh437, 16'sh6ec, -16'shcd0, 16'sh287c};

	localparam int HB2_K     = 5;
	localparam int HB2_SHIFT = 13;
	localparam logic signed [CW-1:0] HB2_CENTER = 16'sh2000;
	localparam logic signed [CW-1:0] HB2_COEF [HB2_K] = '{
		16'sh13, -16'sh78, 16'sh1b6, -16'sh508, 16'sh13b7};

	localparam int HB3_K     = 3;
	localparam int HB3_SHIFT = 9;
	localparam logic signed [CW-1:0] HB3_CENTER = 16'sh200;
	localparam logic signed [CW-1:0] HB3_COEF [HB3_K] = '{
		16'sh7, -16'sh35, 16'sh12e};

	// mixer values in Q15, one entry per eighth of a turn
	localparam logic signed [16:0] MIX_ONE  = 17'sh08000;
	localparam logic signed [16:0] MIX_ROOT = 17'sh05a82;
	localparam int MIX_SHIFT = 15;

	typedef enum logic [1:0] {INTERP_1X, INTERP_2X, INTERP_4X, INTERP_8X}
		interp_e;
	typedef enum logic [1:0] {MOD_NONE, MOD_HALF, MOD_QUARTER, MOD_EIGHTH}
		mod_e;

	typedef struct packed {
		logic signed [DW-1:0] i;
		logic signed [DW-1:0] q;
	} iq_s;

	function automatic logic signed [DW-1:0] sat16(
		input logic signed [ACCW-1:0] v,
		input int                     sh);
		logic signed [ACCW-1:0] s;
		s = v >>> sh;
		if (s > 40'sh7fff)
			return 16'sh7fff;
		else if (s < -40'sh8000)
			return -16'sh8000;
		else
			return s[DW-1:0];
	endfunction

endpackage

// ### test/halfband_interpolation_chain_sva.sv
// Purpose: port checks for the interpolation chain
// Assumes: configuration shadowed from register writes
// Notes:   output latency two edges from capture at 1x
`timescale 1ns/100ps
`default_nettype none
// ********
// checker
// ********
module halfband_chk
	import halfband_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire iq_s        data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic       take_out,
	input wire iq_s        data_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic [7:0] cfg;
	logic [2:0] gap;
	logic [2:0] quiet;
	wire        cwr = wr_in && addr_in == CFG_ADDR;
	always_ff @(posedge clock_in or negedge rstn_in)
		if (!rstn_in) cfg <= CFG_RESET;
		else if (cwr) cfg <= wr_data_in;
	always_ff @(posedge clock_in or negedge rstn_in)
		if (!rstn_in || take_out || cwr) gap <= 3'h0;
		else gap <= gap + 3'h1;
	always_ff @(posedge clock_in or negedge rstn_in)
		if (!rstn_in || cwr) quiet <= 3'h0;
		else if (quiet != 3'h7) quiet <= quiet + 3'h1;
	read_idle_a: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
		else $error("read data outside read slot");
	read_cfg_a: assert property ($past(rd_in && addr_in == CFG_ADDR) |-> rd_data_out == $past(cfg))
		else $error("configuration readback wrong");
	read_unmap_a: assert property ($past(rd_in && addr_in != CFG_ADDR && addr_in != STAT_ADDR) |-> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	stat_low_a: assert property ($past(rd_in && addr_in == STAT_ADDR) |-> rd_data_out[1:0] == 2'h0)
		else $error("status low bits not zero");
	take_pace_a: assert property (!$past(cwr) |-> take_out == (gap == (4'h1 << cfg[7:6]) - 4'h1))
		else $error("take cadence wrong");
	cfg_restart_a: assert property ($past(cwr) |-> take_out)
		else $error("write did not restart cadence");
	pass_plain_a: assert property (cfg[7:2] == 6'h00 && quiet >= 3'h5 |-> data_out == $past(data_in, 2))
		else $error("bypass output wrong");
	mix_half_a: assert property (cfg[7:1] == 7'h08 && quiet >= 3'h6 |->
		((data_out.i == $past(data_in.i, 2)) != ($past(data_out.i) == $past(data_in.i, 3))) &&
		((data_out.q == $past(data_in.q, 2)) == (data_out.i == $past(data_in.i, 2))))
		else $error("half rate mixing wrong");
	real_half_a: assert property (cfg[7:1] == 7'h0a && quiet >= 3'h6 |->
		data_out.q == 16'h0 &&
		((data_out.i == $past(data_in.i, 2)) !=
		($past(data_out.i) == $past(data_in.i, 3))))
		else $error("real mixing wrong");
	stuff_alt_a: assert property (cfg == 8'h08 && quiet >= 3'h5 |->
		((data_out == 32'h0) != ($past(data_out) == 32'h0)) &&
		((data_out == 32'h0) != (data_out == $past(data_in, 2))))
		else $error("zero stuffing pattern wrong");
	cover property (cwr);
	cover property (take_out && cfg[7:6] == 2'h3);
	cover property (rd_in && addr_in == STAT_ADDR);
endmodule
bind halfband_interpolation_chain halfband_chk chk_u (.clock_in, .rstn_in,
	.addr_in, .wr_data_in, .wr_in, .rd_in, .data_in, .rd_data_out, .take_out,
	.data_out);
`default_nettype wire

// ### test/halfband_interpolation_chain_tb_top.sv
// Purpose: self-checking bench for the interpolation chain
// Assumes: stages pass acc >>> log2(centre), saturated
// Notes:   impulse responses are trimmed of zeros at both ends
`timescale 1ns/100ps
`default_nettype none
// ********
// bench
// ********
module halfband_interpolation_chain_tb_top
	import halfband_pkg::*;
;
	logic        clock_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0;
	logic        rnd = 0, arm = 0, pass_on = 0;
	logic [7:0]  addr_in = 0, wr_data_in = 0, rd_data_out, v;
	logic        take_out;
	iq_s         data_in, data_out;
	int          fails = 0, samples_checked = 0, t;
	logic [15:0] rq[$], rv;
	logic [31:0] eq[$], pq[$];
	bit          rd_d, run;
	int cf[19] = '{8, -29, 67, -134, 244, -414, 673, -1079, 1772, -3280,
		10364, 19, -120, 438, -1288, 5047, 7, -53, 302};
	int kk[3] = '{11, 5, 3}, oo[3] = '{0, 11, 16}, ss[3] = '{14, 13, 9};
	always #25 clock_in = ~clock_in;
	halfband_interpolation_chain dut_u (.clock_in, .rstn_in, .addr_in,
		.wr_data_in, .wr_in, .rd_in, .data_in, .rd_data_out, .take_out,
		.data_out);
	sample_source src_u (.clock_in, .rstn_in, .take_in(take_out),
		.rnd_in(rnd), .arm_in(arm), .data_out(data_in));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d, m);
		addr_in <= a;
		wr_data_in <= d;
		if (w) wr_in <= 1;
		else rd_in <= 1;
		if (!w) rq.push_back({m, d});
		@(posedge clock_in);
		if (w) wr_in <= 0;
		else rd_in <= 0;
	endtask
	function automatic int tap(int s, int j);
		int m = 2 * kk[s] - 1;
		int d = j < m ? j : 4 * kk[s] - 2 - j;
		return j == m ? 1 << ss[s] : d % 2 ? 0 : cf[oo[s] + d / 2];
	endfunction
	// full-rate cascade response to one impulse of 16384
	task automatic impulse(input int n);
		int r[$], u[$], a;
		r = {16384};
		for (int s = 0; s < n; s++)
		begin
			u = {};
			foreach (r[i]) u = {u, r[i], 0};
			r = {};
			for (int j = 0; j < u.size() + 4 * kk[s] - 2; j++)
			begin
				a = 0;
				for (int k = 0; k < 4 * kk[s] - 1; k++)
					if (j >= k && j - k < u.size()) a += tap(s, k) * u[j - k];
				a = a >>> ss[s];
				r.push_back(a > 32767 ? 32767 : a < -32768 ? -32768 : a);
			end
		end
		while (r[0] == 0) void'(r.pop_front());
		while (r[$] == 0) void'(r.pop_back());
		foreach (r[i]) eq.push_back({2{16'(r[i])}});
	endtask
	always @(posedge clock_in)
	begin
		if (rd_d)
		begin
			rv = rq.pop_front();
			check(rd_data_out & rv[15:8], {8'h00, rv[7:0]});
		end
		rd_d = rd_in;
		if (pass_on && take_out)
		begin
			if (pq.size() == 2) check(data_out, pq.pop_front());
			pq.push_back(data_in);
		end
		if (eq.size() > 0 && (run || data_out !== '0))
		begin
			run = 1;
			check(data_out, eq.pop_front());
		end
		else run = 0;
	end
	initial
	begin
		void'($urandom(32'ha045));
		repeat (4) @(posedge clock_in);
		rstn_in <= 1;
		@(posedge clock_in);
		bus(0, CFG_ADDR, 8'h00, 8'hff);
		bus(1, 8'h07, 8'hff, 8'h00);
		bus(0, 8'h07, 8'h00, 8'hff);
		bus(1, STAT_ADDR, 8'hff, 8'h00);
		bus(0, CFG_ADDR, 8'h00, 8'hff);
		for (int i = 0; i < 16; i++)
		begin
			v = {i[3:0], 4'($urandom)};
			bus(1, CFG_ADDR, v, 8'h00);
			bus(0, CFG_ADDR, v, 8'hff);
		end
		bus(1, CFG_ADDR, 8'h00, 8'h00);
		bus(0, STAT_ADDR, 8'h00, 8'h03);
		rnd <= 1;
		repeat (4) @(posedge clock_in);
		pass_on <= 1;
		repeat (200) @(posedge clock_in);
		pass_on <= 0;
		bus(1, CFG_ADDR, 8'h10, 8'h00);
		pq = {};
		repeat (100) @(posedge clock_in);
		bus(1, CFG_ADDR, 8'h14, 8'h00);
		repeat (50) @(posedge clock_in);
		bus(1, CFG_ADDR, 8'h08, 8'h00);
		repeat (50) @(posedge clock_in);
		for (int n = 1; n <= 3; n++)
		begin
			rnd <= 0;
			bus(1, CFG_ADDR, 8'(n << 6), 8'h00);
			repeat (300) @(posedge clock_in);
			impulse(n);
			arm <= 1;
			@(posedge clock_in);
			arm <= 0;
			for (t = 0; t < 800 && eq.size() > 0; t++) @(posedge clock_in);
			if (eq.size() > 0)
			begin
				fails++;
				complete_run();
			end
		end
		complete_run();
	end
endmodule
`default_nettype wire

// ### test/sample_source.sv
// Purpose: upstream sample source for the interpolation chain
// Assumes: a new sample is offered after a taken one, or when arm_in loads the impulse
// Notes:   arm loads one impulse, otherwise random or zero
`timescale 1ns/100ps
`default_nettype none
// ********
// source model
// ********
module sample_source
	import halfband_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic rstn_in,
	input  wire logic take_in,
	input  wire logic rnd_in,
	input  wire logic arm_in,
	output var  iq_s  data_out
);
	// positive nonzero randoms keep mixer sign flips visible
	always_ff @(posedge clock_in or negedge rstn_in)
		if (!rstn_in)
			data_out <= '0;
		else if (arm_in)
			data_out <= 32'h40004000;
		else if (take_in)
			data_out <= rnd_in ? ($urandom & 32'h3fff3fff) | 32'h00010001 : '0;
endmodule
`default_nettype wire
